//--- verilog/uarls_params.svh
// Named offsets, bit positions, reset values and sizes of the line-status block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef UARLS_PARAMS_SVH
`define UARLS_PARAMS_SVH

`define UARLS_ADDR_W       3
`define UARLS_OFS_DATA     3'h0
`define UARLS_OFS_CTRL     3'h2
`define UARLS_OFS_LCF      3'h5

`define UARLS_CTRL_FIFO_EN 0
`define UARLS_CTRL_THRE_IE 1
`define UARLS_CTRL_RESET   8'h00

`define UARLS_LCF_DR       0
`define UARLS_LCF_OE       1
`define UARLS_LCF_PE       2
`define UARLS_LCF_FE       3
`define UARLS_LCF_BI       4
`define UARLS_LCF_THRE     5
`define UARLS_LCF_TEMT     6
`define UARLS_LCF_FERR     7

`define UARLS_BYTE_ZERO    8'h00
`define UARLS_DATA_W       8
`define UARLS_FIFO_DEPTH   16

`endif

//--- verilog/uarls_pkg.sv
// Types shared by the line-status block and its FIFO.
// Assumes nothing beyond a SystemVerilog compiler.
package uarls_pkg;

  // One receive FIFO word: error marks travel with their character
  typedef struct packed {
    logic       brk;
    logic       frame;
    logic       parity;
    logic [7:0] data;
  } uarls_rx_entry_type;

  typedef enum logic {
    BRK_IDLE,
    BRK_HELD
  } uarls_brk_state_type;

endpackage

//--- verilog/uarls_fifo_if.sv
// Carrier between the line-status block and its FIFO instances.
// Assumes one clock domain; the store side owns ready, valid, data out and level.
`timescale 1ns/1ps
interface uarls_fifo_if #(
  parameter int W  = 8,
  parameter int CW = 5
);
  logic          push_valid;
  logic          push_ready;
  logic [W-1:0]  push_data;
  logic          pop_valid;
  logic          pop_ready;
  logic [W-1:0]  pop_data;
  logic          flush;
  logic [CW-1:0] level;

  modport store (
    input  push_valid, push_data, pop_ready, flush,
    output push_ready, pop_valid, pop_data, level
  );
  modport user (
    output push_valid, push_data, pop_ready, flush,
    input  push_ready, pop_valid, pop_data, level
  );
endinterface

//--- verilog/uarls_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes DEPTH is a power of two and the interface CW equals $clog2(DEPTH+1).
`timescale 1ns/1ps
module uarls_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic   i_sys_clk,  // System clock
  input  wire logic   i_sys_rst,  // Asynchronous reset, active high
  uarls_fifo_if.store f           // Fill and drain sides
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          do_push;
  logic          do_pop;

  assign f.push_ready = (count != CW'(DEPTH));
  assign f.pop_valid  = (count != '0);
  assign f.pop_data   = mem[rd_ptr];
  assign f.level      = count;
  assign do_push      = f.push_valid & f.push_ready;
  assign do_pop       = f.pop_ready & f.pop_valid;

  always_ff @(posedge i_sys_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= f.push_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (f.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

//--- verilog/uarls_line_status.sv
// Line-status flags of one UART channel with its receive and transmit FIFOs.
// Assumes a receiver that pulses one completed character with its error marks,
// a transmitter that takes characters by pulse, and a CPU on a plain register port.
// Operation
// - FIFOs off: idle flag high only when holding and shift registers both empty.
// - FIFO mode: idle flag high only when transmit FIFO and shift register empty.
// - FIFOs off: holding-empty sets on move to shifter, clears on CPU load.
// - Holding-empty with its enable on requests an interrupt.
// - FIFO mode: holding-empty set while transmit FIFO empty, cleared on any write.
// - Break flag set on line low for a whole frame; otherwise reads zero.
// - FIFO mode: one break character stored per break condition.
// - Framing-error flag set when a character lacks a valid stop bit.
// - FIFO mode: framing and parity flags belong to the head character.
// - Parity-error flag set when received parity mismatches the configured parity.
// - Overrun flag set when a character completes while the FIFO is full.
// - On overrun the new character is dropped; FIFO contents stay intact.
// - Data-ready set while holding register or FIFO holds a character.
// - Data-ready clear when nothing is held; cleared is the default.
// - FIFO mode: FIFO error flag set while any stored character carries an error mark.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "uarls_params.svh"
module uarls_line_status #(
  parameter int DEPTH = `UARLS_FIFO_DEPTH
) (
  input  wire logic                     i_sys_clk,       // 40 MHz system clock
  input  wire logic                     i_sys_rst,       // Asynchronous reset, active high
  input  wire logic [`UARLS_ADDR_W-1:0] i_addr,          // Register address
  input  wire logic [`UARLS_DATA_W-1:0] i_wr_data,       // Register write data
  input  wire logic                     i_wr_stb,        // Write strobe, one cycle
  input  wire logic                     i_rd_stb,        // Read strobe, one cycle
  output logic      [`UARLS_DATA_W-1:0] o_rd_data,       // Read data, cycle after strobe
  input  wire logic                     i_rx_char_valid, // Receiver completed a character
  input  wire logic [`UARLS_DATA_W-1:0] i_rx_char,       // Received character
  input  wire logic                     i_rx_parity_err, // Parity mismatch on it
  input  wire logic                     i_rx_frame_err,  // Missing stop bit on it
  input  wire logic                     i_rx_break,      // Line was low for a whole frame
  input  wire logic                     i_rx_line,       // Serial receive line level
  input  wire logic                     i_shift_load,    // Shifter takes the next character
  input  wire logic                     i_shift_done,    // Shifter finished its character
  output logic      [`UARLS_DATA_W-1:0] o_tx_data,       // Character handed to shifter
  output logic                          o_tx_pending,    // A character awaits the shifter
  output logic                          o_thre_irq,      // Holding-empty interrupt request
  output logic                          o_fifo_mode      // FIFO mode is on
);
  import uarls_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);
  localparam int RW = $bits(uarls_rx_entry_type);

  uarls_fifo_if #(.W(RW), .CW(CW))              rx_q ();
  uarls_fifo_if #(.W(`UARLS_DATA_W), .CW(CW))   tx_q ();

  uarls_fifo #(.W(RW), .DEPTH(DEPTH)) u_rx_fifo (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .f         (rx_q)
  );

  uarls_fifo #(.W(`UARLS_DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .f         (tx_q)
  );

  logic [`UARLS_DATA_W-1:0] ctrl;
  logic                     fifo_en;
  logic                     thre_ie;
  logic                     ctrl_wr;
  logic                     mode_flip;
  logic                     lcf_rd;
  logic                     cpu_tx_wr;
  logic                     cpu_rx_rd;

  // Transmit side
  logic                     tx_full_eff;
  logic                     tx_push;
  logic                     tx_pop;
  logic [CW-1:0]            next_tx_level;
  logic                     shift_busy;
  logic                     next_shift_busy;
  logic                     thre;
  logic                     temt;

  // Receive side
  uarls_brk_state_type      brk_state;
  uarls_rx_entry_type       rx_in;
  uarls_rx_entry_type       rx_head;
  logic                     rx_full_eff;
  logic                     rx_dup_brk;
  logic                     rx_new;
  logic                     rx_push;
  logic                     rx_pop;
  logic                     overrun_evt;
  logic [CW-1:0]            next_rx_level;
  logic                     head_fresh;
  logic                     next_head_fresh;
  logic [CW-1:0]            err_count;
  logic [CW-1:0]            next_err_count;
  logic                     in_err;
  logic                     head_err;

  // Flags
  logic                     data_ready;
  logic                     overrun;
  logic                     parity_flag;
  logic                     frame_flag;
  logic                     break_flag;
  logic                     fifo_err;
  logic [`UARLS_DATA_W-1:0] lcf_byte;

  assign fifo_en   = ctrl[`UARLS_CTRL_FIFO_EN];
  assign thre_ie   = ctrl[`UARLS_CTRL_THRE_IE];
  assign ctrl_wr   = i_wr_stb && (i_addr == `UARLS_OFS_CTRL);
  assign cpu_tx_wr = i_wr_stb && (i_addr == `UARLS_OFS_DATA);
  assign cpu_rx_rd = i_rd_stb && (i_addr == `UARLS_OFS_DATA);
  assign lcf_rd    = i_rd_stb && (i_addr == `UARLS_OFS_LCF);
  // Changing mode empties both queues so stale depth-1 and FIFO contents never mix
  assign mode_flip = ctrl_wr && (i_wr_data[`UARLS_CTRL_FIFO_EN] != fifo_en);

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl <= `UARLS_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= i_wr_data;
    end
  end

  // Transmit queue: with FIFOs off it acts as a single holding register
  assign tx_full_eff     = fifo_en ? !tx_q.push_ready : tx_q.pop_valid;
  assign tx_push         = cpu_tx_wr && !tx_full_eff;
  assign tx_pop          = i_shift_load && tx_q.pop_valid;
  assign tx_q.push_valid = tx_push;
  assign tx_q.push_data  = i_wr_data;
  assign tx_q.pop_ready  = i_shift_load;
  assign tx_q.flush      = mode_flip;

  always_comb begin
    next_tx_level = tx_q.level;
    if (mode_flip) begin
      next_tx_level = '0;
    end else if (tx_push && !tx_pop) begin
      next_tx_level = tx_q.level + 1'b1;
    end else if (tx_pop && !tx_push) begin
      next_tx_level = tx_q.level - 1'b1;
    end
  end

  // Load into the shifter wins over a finish in the same cycle
  // Busy spans from the load until the shifter reports its finish
  always_comb begin
    next_shift_busy = shift_busy;
    if (i_shift_done) begin
      next_shift_busy = 1'b0;
    end
    if (tx_pop) begin
      next_shift_busy = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_busy <= 1'b0;
    end else begin
      shift_busy <= next_shift_busy;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_data <= `UARLS_BYTE_ZERO;
    end else if (tx_pop) begin
      o_tx_data <= tx_q.pop_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      thre         <= 1'b1;
      temt         <= 1'b1;
      o_tx_pending <= 1'b0;
    end else begin
      thre         <= (next_tx_level == '0);
      temt         <= (next_tx_level == '0) && !next_shift_busy;
      o_tx_pending <= (next_tx_level != '0);
    end
  end

  // Mirrors take a control write at the same edge as the control register itself
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_thre_irq  <= 1'b0;
      o_fifo_mode <= 1'b0;
    end else begin
      o_thre_irq  <= (next_tx_level == '0) &&
                     (ctrl_wr ? i_wr_data[`UARLS_CTRL_THRE_IE] : thre_ie);
      o_fifo_mode <= ctrl_wr ? i_wr_data[`UARLS_CTRL_FIFO_EN] : fifo_en;
    end
  end

  // Receive queue: with FIFOs off it acts as a single holding register
  assign rx_full_eff = fifo_en ? !rx_q.push_ready : rx_q.pop_valid;
  // A break that is still held produces no second character
  assign rx_dup_brk  = i_rx_break && (brk_state == BRK_HELD);
  assign rx_new      = i_rx_char_valid && !rx_dup_brk && !mode_flip;
  assign rx_push     = rx_new && !rx_full_eff;
  assign overrun_evt = rx_new && rx_full_eff;
  assign rx_pop      = cpu_rx_rd && rx_q.pop_valid;
  assign rx_head     = uarls_rx_entry_type'(rx_q.pop_data);

  always_comb begin
    rx_in        = '0;
    rx_in.data   = i_rx_char;
    rx_in.parity = i_rx_parity_err;
    rx_in.frame  = i_rx_frame_err;
    rx_in.brk    = i_rx_break;
  end

  assign in_err          = i_rx_parity_err || i_rx_frame_err || i_rx_break;
  assign head_err        = rx_head.parity || rx_head.frame || rx_head.brk;
  assign rx_q.push_valid = rx_push;
  assign rx_q.push_data  = rx_in;
  assign rx_q.pop_ready  = cpu_rx_rd;
  assign rx_q.flush      = mode_flip;

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      brk_state <= BRK_IDLE;
    end else begin
      unique case (brk_state)
        BRK_IDLE: begin
          if (i_rx_char_valid && i_rx_break) begin
            brk_state <= BRK_HELD;
          end
        end
        BRK_HELD: begin
          if (i_rx_line) begin
            brk_state <= BRK_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    next_rx_level = rx_q.level;
    if (mode_flip) begin
      next_rx_level = '0;
    end else if (rx_push && !rx_pop) begin
      next_rx_level = rx_q.level + 1'b1;
    end else if (rx_pop && !rx_push) begin
      next_rx_level = rx_q.level - 1'b1;
    end
  end

  // A new character reaches the head when it enters an empty queue or a pop exposes one
  always_comb begin
    next_head_fresh = 1'b0;
    if (!mode_flip) begin
      if (rx_push && (rx_q.level == '0)) begin
        next_head_fresh = 1'b1;
      end
      if (rx_pop && (next_rx_level != '0)) begin
        next_head_fresh = 1'b1;
      end
    end
  end

  always_comb begin
    next_err_count = err_count;
    if (mode_flip) begin
      next_err_count = '0;
    end else begin
      if (rx_push && in_err) begin
        next_err_count = next_err_count + 1'b1;
      end
      if (rx_pop && head_err) begin
        next_err_count = next_err_count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      head_fresh <= 1'b0;
      err_count  <= '0;
    end else begin
      head_fresh <= next_head_fresh;
      err_count  <= next_err_count;
    end
  end

  // Visible flags follow this edge's push and pop, not last cycle's level
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      data_ready <= 1'b0;
      fifo_err   <= 1'b0;
    end else begin
      data_ready <= (next_rx_level != '0);
      fifo_err   <= fifo_en && (next_err_count != '0);
    end
  end

  // Sticky error flags: a setting event beats the clearing read in the same cycle
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      overrun     <= 1'b0;
      parity_flag <= 1'b0;
      frame_flag  <= 1'b0;
      break_flag  <= 1'b0;
    end else begin
      overrun     <= (overrun && !lcf_rd) || overrun_evt;
      parity_flag <= (parity_flag && !lcf_rd) || (head_fresh && rx_head.parity);
      frame_flag  <= (frame_flag && !lcf_rd) || (head_fresh && rx_head.frame);
      break_flag  <= (break_flag && !lcf_rd) || (head_fresh && rx_head.brk);
    end
  end

  always_comb begin
    lcf_byte                  = `UARLS_BYTE_ZERO;
    lcf_byte[`UARLS_LCF_DR]   = data_ready;
    lcf_byte[`UARLS_LCF_OE]   = overrun;
    lcf_byte[`UARLS_LCF_PE]   = parity_flag;
    lcf_byte[`UARLS_LCF_FE]   = frame_flag;
    lcf_byte[`UARLS_LCF_BI]   = break_flag;
    lcf_byte[`UARLS_LCF_THRE] = thre;
    lcf_byte[`UARLS_LCF_TEMT] = temt;
    lcf_byte[`UARLS_LCF_FERR] = fifo_err;
  end

  // Read data is valid only in the cycle after the strobe and zero otherwise
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= `UARLS_BYTE_ZERO;
    end else if (i_rd_stb) begin
      unique case (i_addr)
        `UARLS_OFS_DATA: o_rd_data <= rx_q.pop_valid ? rx_head.data : `UARLS_BYTE_ZERO;
        `UARLS_OFS_CTRL: o_rd_data <= ctrl;
        `UARLS_OFS_LCF:  o_rd_data <= lcf_byte;
        default:         o_rd_data <= `UARLS_BYTE_ZERO;
      endcase
    end else begin
      o_rd_data <= `UARLS_BYTE_ZERO;
    end
  end
endmodule

//--- bench/uarls_line_status_assertions.sv
// Port-level checker for the line-status block, bound below.
// Assumes the register map and bit layout of the shared header.
`timescale 1ns/1ps
`include "uarls_params.svh"
module uarls_line_status_assertions (
  input wire logic       i_sys_clk,       // Clock
  input wire logic       i_sys_rst,       // Reset
  input wire logic [2:0] i_addr,          // Address
  input wire logic [7:0] i_wr_data,       // Write data
  input wire logic       i_wr_stb,        // Write strobe
  input wire logic       i_rd_stb,        // Read strobe
  input wire logic [7:0] o_rd_data,       // Read data
  input wire logic       i_rx_char_valid, // Rx char
  input wire logic [7:0] i_rx_char,       // Rx data
  input wire logic       i_rx_parity_err, // Rx parity mark
  input wire logic       i_rx_frame_err,  // Rx frame mark
  input wire logic       i_rx_break,      // Rx break mark
  input wire logic       i_rx_line,       // Line level
  input wire logic       i_shift_load,    // Shifter load
  input wire logic       i_shift_done,    // Shifter done
  input wire logic [7:0] o_tx_data,       // Tx data
  input wire logic       o_tx_pending,    // Tx queued
  input wire logic       o_thre_irq,      // Irq request
  input wire logic       o_fifo_mode      // FIFO mode
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_lcf_read;
    i_rd_stb && i_addr == `UARLS_OFS_LCF;
  endsequence
  sequence s_rx_push;
    i_rx_char_valid && !i_rd_stb && !i_rx_break;
  endsequence
  // A status read comes exactly two edges after a character
  sequence s_rx_then_read;
    s_rx_push ##1 !i_rd_stb ##1 s_lcf_read;
  endsequence
  a_rd_idle_zero: assert property (!i_rd_stb |=> o_rd_data == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_reads_zero: assert property (i_rd_stb && i_addr != `UARLS_OFS_DATA &&
    i_addr != `UARLS_OFS_CTRL && i_addr != `UARLS_OFS_LCF |=> o_rd_data == 8'h00)
    else $error("unmapped address read not zero");
  a_mode_follows_ctrl: assert property (i_wr_stb && i_addr == `UARLS_OFS_CTRL |=>
    o_fifo_mode == $past(i_wr_data[`UARLS_CTRL_FIFO_EN])) else $error("mode bit not taken");
  a_write_sets_pending: assert property (
    i_wr_stb && i_addr == `UARLS_OFS_DATA && !i_shift_load |=> o_tx_pending)
    else $error("tx write left nothing pending");
  a_thre_tracks_queue: assert property (
    s_lcf_read |=> o_rd_data[`UARLS_LCF_THRE] == !$past(o_tx_pending))
    else $error("holding-empty wrong");
  a_idle_needs_empty: assert property (
    s_lcf_read |=> !o_rd_data[`UARLS_LCF_TEMT] || o_rd_data[`UARLS_LCF_THRE])
    else $error("idle while held");
  a_irq_needs_empty: assert property (o_thre_irq |-> !o_tx_pending)
    else $error("irq while holding a char");
  a_ferr_fifo_only: assert property (
    s_lcf_read and !o_fifo_mode |=> !o_rd_data[`UARLS_LCF_FERR])
    else $error("fifo error outside fifo mode");
  a_dr_after_rx: assert property (s_rx_then_read |=> o_rd_data[`UARLS_LCF_DR])
    else $error("data ready missing after rx");
endmodule
bind uarls_line_status uarls_line_status_assertions u_chk (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
  .i_rx_char_valid(i_rx_char_valid), .i_rx_char(i_rx_char), .i_rx_parity_err(i_rx_parity_err),
  .i_rx_frame_err(i_rx_frame_err), .i_rx_break(i_rx_break), .i_rx_line(i_rx_line),
  .i_shift_load(i_shift_load), .i_shift_done(i_shift_done), .o_tx_data(o_tx_data),
  .o_tx_pending(o_tx_pending), .o_thre_irq(o_thre_irq), .o_fifo_mode(o_fifo_mode));

//--- bench/uarls_shifter_model.sv
// Transmit shifter model: takes a queued char, shifts for a while, reports done.
// Assumes pending is the block's registered queue-not-empty flag.
`timescale 1ns/1ps
module uarls_shifter_model #(
  parameter int SHIFT_CYCLES = 6
) (
  input  wire logic i_sys_clk,  // Clock
  input  wire logic i_sys_rst,  // Reset
  input  wire logic i_pending,  // Char waiting
  input  wire logic i_stall,    // Hold off loading
  output logic      o_shift_load, // Take a char
  output logic      o_shift_done  // Char sent
);
  logic [7:0] cnt;
  logic       busy;
  // Only loads while idle, so a stale pending flag is never acted on twice
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {o_shift_load, o_shift_done, busy} <= 3'h0;
      cnt <= 8'h00;
    end else begin
      o_shift_load <= 1'b0;
      o_shift_done <= 1'b0;
      if (!busy && i_pending && !i_stall) begin
        o_shift_load <= 1'b1;
        busy <= 1'b1;
        cnt <= 8'(SHIFT_CYCLES);
      end else if (busy && cnt == 8'h00) begin
        o_shift_done <= 1'b1;
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

//--- bench/uarls_line_status_tb_top.sv
// Self-checking bench for the line-status block with random rx and tx data.
// Assumes the checker binds itself and the shifter model drives load and done.
`timescale 1ns/1ps
module uarls_line_status_tb_top;
  logic        i_sys_clk, i_sys_rst, i_wr_stb, i_rd_stb, i_rx_char_valid, i_rx_line;
  logic        i_rx_parity_err, i_rx_frame_err, i_rx_break, stall, shift_load, shift_done;
  logic        load_seen, o_tx_pending, o_thre_irq, o_fifo_mode;
  logic [2:0]  i_addr;
  logic [7:0]  i_wr_data, i_rx_char, o_rd_data, o_tx_data, d;
  logic [7:0]  rxd [17];
  logic [7:0]  txq [$];
  logic [31:0] seed;
  int          num_errors, total_checks;

  uarls_line_status dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
    .i_rx_char_valid(i_rx_char_valid), .i_rx_char(i_rx_char), .i_rx_parity_err(i_rx_parity_err),
    .i_rx_frame_err(i_rx_frame_err), .i_rx_break(i_rx_break), .i_rx_line(i_rx_line),
    .i_shift_load(shift_load), .i_shift_done(shift_done), .o_tx_data(o_tx_data),
    .o_tx_pending(o_tx_pending), .o_thre_irq(o_thre_irq), .o_fifo_mode(o_fifo_mode));
  uarls_shifter_model u_shift (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_pending(o_tx_pending), .i_stall(stall),
    .o_shift_load(shift_load), .o_shift_done(shift_done));

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr_stb <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_stb <= 1'b0;
    #1 v = o_rd_data;
  endtask

  task automatic rx(input logic [7:0] v, input logic pe, input logic fe, input logic brk);
    @(posedge i_sys_clk);
    i_rx_char <= v;
    {i_rx_parity_err, i_rx_frame_err, i_rx_break} <= {pe, fe, brk};
    i_rx_char_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_rx_char_valid <= 1'b0;
  endtask

  task automatic wait_idle();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 200 && !s[6]; i++)
      rd(3'h5, s);
    if (!s[6]) begin
      num_errors++;
      $display("Error at %0t: transmitter never idle", $time);
      tally_and_finish();
    end
  endtask

  // Every char the shifter takes must be the oldest one accepted
  always @(posedge i_sys_clk) begin
    load_seen <= shift_load;
    if (load_seen && txq.size() == 0) begin
      num_errors++;
      $display("Error at %0t: load with nothing queued", $time);
    end else if (load_seen)
      check(o_tx_data, txq.pop_front());
  end

  initial begin
    {i_sys_rst, i_rx_line} = 2'b11;
    {i_wr_stb, i_rd_stb, i_rx_char_valid, i_rx_parity_err, i_rx_frame_err, i_rx_break} = '0;
    {i_addr, i_wr_data, i_rx_char, stall, load_seen} = '0;
    seed = 32'h0000C845;
    num_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rd(3'h5, d);
    check(d, 8'h60);
    rd(3'h7, d);
    check(d, 8'h00);
    // Holding register mode with interrupt enabled; second write is refused
    wr(3'h2, 8'h02);
    repeat (2) @(posedge i_sys_clk);
    #1 check({7'h00, o_thre_irq}, 8'h01);
    stall <= 1'b1;
    d = rnd();
    txq.push_back(d);
    wr(3'h0, d);
    wr(3'h0, rnd());
    rd(3'h5, d);
    check(d, 8'h00);
    check({7'h00, o_thre_irq}, 8'h00);
    stall <= 1'b0;
    wait_idle();
    rd(3'h5, d);
    check(d, 8'h60);
    check({7'h00, o_thre_irq}, 8'h01);
    // FIFO mode: fill the transmit FIFO past full while the shifter stalls
    wr(3'h2, 8'h03);
    stall <= 1'b1;
    for (int k = 0; k < 17; k++) begin
      d = rnd();
      if (k < 16)
        txq.push_back(d);
      wr(3'h0, d);
    end
    rd(3'h5, d);
    check(d, 8'h00);
    stall <= 1'b0;
    wait_idle();
    rd(3'h5, d);
    check(d, 8'h60);
    check(8'(txq.size()), 8'h00);
    // Receive FIFO: marks on chars 1 and 2, one char too many
    for (int k = 0; k < 17; k++) begin
      rxd[k] = rnd();
      rx(rxd[k], k == 1, k == 2, 1'b0);
    end
    rd(3'h5, d);
    check(d, 8'hE3);
    rd(3'h5, d);
    check(d, 8'hE1);
    for (int k = 0; k < 16; k++) begin
      rd(3'h0, d);
      check(d, rxd[k]);
      if (k < 2) begin
        repeat (3) @(posedge i_sys_clk);
        rd(3'h5, d);
        check(d, k == 0 ? 8'hE5 : 8'hE9);
      end
    end
    rd(3'h5, d);
    check(d, 8'h60);
    rd(3'h0, d);
    check(d, 8'h00);
    // A long break yields two break chars; only the first is stored
    @(posedge i_sys_clk) i_rx_line <= 1'b0;
    rx(8'h00, 1'b0, 1'b0, 1'b1);
    rx(8'h00, 1'b0, 1'b0, 1'b1);
    i_rx_line <= 1'b1;
    rd(3'h5, d);
    check(d, 8'hF1);
    rd(3'h0, d);
    check(d, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    rd(3'h5, d);
    check(d, 8'h60);
    tally_and_finish();
  end
endmodule
